// [pmctl_mgmt_model.sv]
// Purpose: Station management master that runs frames on the management pins.
// Assumes: Management clock half period of 5 reference cycles, well above the minimum 4.
// Notes:   Releases the data wire in turnaround and read data; mdc idles low between frames.
`timescale 1ns/1ps
module pmctl_mgmt_model (
    input wire logic ref_clk, // Reference clock
    output logic mdc, // Management clock
    output logic mdioDrv, // Data value driven
    output logic mdioDrvEn, // High while driving data
    input wire logic mdioWire // Resolved data wire
);
    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    // Idle: clock still, wire released to its pull-up
    initial begin
        mdc = 1'b0;
        mdioDrv = 1'b0;
        mdioDrvEn = 1'b0;
    end

    // Data changes while mdc is low so it is settled at the rise
    task automatic bitCycle(input logic val, input logic drive, output logic seen);
        @(posedge ref_clk);
        mdc <= 1'b0;
        mdioDrv <= val;
        mdioDrvEn <= drive;
        repeat (5) @(posedge ref_clk);
        seen = mdioWire;
        mdc <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask

    // Whole frame; reads release the wire from turnaround on
    task automatic runFrame(input logic [1:0] op, input logic [4:0] phyAddr,
            input logic [4:0] regAddr, input logic [15:0] wrData,
            output logic [15:0] rdData, output logic taSeen);
        logic [13:0] hdr;
        logic seen;
        logic wr;
        hdr = {2'b01, op, phyAddr, regAddr};
        wr = (op == 2'b01);
        for (int i = 0; i < 32; i++) begin
            bitCycle(1'b1, 1'b1, seen);
        end
        for (int i = 13; i >= 0; i--) begin
            bitCycle(hdr[i], 1'b1, seen);
        end
        bitCycle(1'b1, wr, seen);
        bitCycle(1'b0, wr, taSeen);
        for (int i = 15; i >= 0; i--) begin
            bitCycle(wrData[i], wr, seen);
            rdData[i] = seen;
        end
        @(posedge ref_clk);
        mdc <= 1'b0;
        mdioDrvEn <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule

// [pmctl_phy_ctrl.sv]
// Purpose: PHY basic control register behind the serial management pins,
//          with soft reset, loopback and mode outputs.
// Assumes: mdc at most a few MHz; MAC and line data are on ref_clk.
// Notes:   Only register 0 at this PHY address is answered; others stay silent.
`timescale 1ns/1ps
// Summary of operation
// - Control register resets to 0x3100, read and written over management pins.
// - Reset values give normal operation without any management write.
// - Writing bit 15 restores register defaults and resets internal state machines.
// - Bit 15 clears itself when the soft reset has run its time.
// - Bit 14 set detaches transmit and receive paths from the medium.
// - In loopback, MAC transmit data returns on the MAC receive path.
module pmctl_phy_ctrl
    import pmctl_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter int SOFT_RST_CYCLES = PMCTL_SOFT_RST_CYCLES
) (
    input wire logic ref_clk, // Reference clock, 100 MHz
    input wire logic sys_rst, // Async reset, high
    input wire logic mdc, // Management clock pin
    input wire logic mdioIn, // Management data pin, input side
    output logic mdioOut, // Management data pin, output side
    output logic mdioOe, // Management data drive enable
    input wire logic [3:0] macTxd, // Transmit nibble from MAC
    input wire logic macTxEn, // Transmit enable from MAC
    output logic [3:0] macRxd, // Receive nibble to MAC
    output logic macRxDv, // Receive valid to MAC
    output logic [3:0] lineTxd, // Transmit nibble to medium side
    output logic lineTxEn, // Transmit enable to medium side
    input wire logic [3:0] lineRxd, // Receive nibble from medium side
    input wire logic lineRxDv, // Receive valid from medium side
    output logic phyStateRst, // Soft reset to PHY state machines
    output pmctl_mode_t phyMode // Mode fields of the control register
);
    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (SOFT_RST_CYCLES < 1 || SOFT_RST_CYCLES > 65535) begin : g_bad_rst
        $error("pmctl_phy_ctrl: SOFT_RST_CYCLES out of range");
    end

    localparam logic [15:0] RST_LAST = 16'(SOFT_RST_CYCLES - 1);

    logic mdcS;
    logic mdioS;
    logic mdcD_r;
    logic mdcRise;
    pmctl_state_t state_r;
    logic [5:0] ones_r;
    logic [4:0] bitCnt_r;
    logic [11:0] hdr_r;
    logic [15:0] shift_r;
    logic [15:0] ctrlReg_r;
    logic [15:0] rstCnt_r;
    logic [15:0] wrData_r;
    logic wrStb_r;
    logic addrHit;
    logic rdHit;
    logic wrHit;
    logic [15:0] rdValue;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pmctl_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .din({mdc, mdioIn}),
        .dout({mdcS, mdioS})
    );

    // Rising edge of the synchronised management clock
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mdcD_r <= 1'b0;
        end else begin
            mdcD_r <= mdcS;
        end
    end
    assign mdcRise = mdcS & ~mdcD_r;

    // ----------------------------------------------------------------
    // Frame decode
    // ----------------------------------------------------------------
    // Header is opcode, PHY address, register address
    assign addrHit = (hdr_r[9:5] == PHY_ADDR) && (hdr_r[4:0] == PMCTL_REG_BASIC_CONTROL);
    assign rdHit = addrHit && (hdr_r[11:10] == PMCTL_OP_READ);
    assign wrHit = addrHit && (hdr_r[11:10] == PMCTL_OP_WRITE);
    // Reserved bits are never stored, so they read as zero
    assign rdValue = ctrlReg_r & PMCTL_CTRL_WRITE_MASK;

    // Serial frame engine; stepped only on mdc rising edges
    // serial read and write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_PRE;
            ones_r <= '0;
            bitCnt_r <= '0;
            hdr_r <= '0;
            shift_r <= '0;
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
            wrStb_r <= 1'b0;
            wrData_r <= '0;
        end else begin
            wrStb_r <= 1'b0;
            if (mdcRise) begin
                case (state_r)
                    ST_PRE: begin
                        if (mdioS) begin
                            if (ones_r != PMCTL_PREAMBLE_BITS) begin
                                ones_r <= ones_r + 6'h01;
                            end
                        end else begin
                            // A zero after a full preamble is the first start bit
                            if (ones_r == PMCTL_PREAMBLE_BITS) begin
                                state_r <= ST_START;
                            end
                            ones_r <= '0;
                        end
                    end
                    ST_START: begin
                        bitCnt_r <= '0;
                        state_r <= mdioS ? ST_HDR : ST_PRE;
                    end
                    ST_HDR: begin
                        hdr_r <= {hdr_r[10:0], mdioS};
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (bitCnt_r == PMCTL_HDR_BITS - 5'h01) begin
                            bitCnt_r <= '0;
                            state_r <= ST_TA;
                        end
                    end
                    ST_TA: begin
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (bitCnt_r == 5'h00) begin
                            // Drive the zero of the turnaround
                            if (rdHit) begin
                                mdioOe <= 1'b1;
                                mdioOut <= 1'b0;
                            end
                        end else begin
                            bitCnt_r <= '0;
                            state_r <= ST_DATA;
                            if (rdHit) begin
                                mdioOut <= rdValue[15];
                                shift_r <= {rdValue[14:0], 1'b0};
                            end
                        end
                    end
                    ST_DATA: begin
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (rdHit) begin
                            mdioOut <= shift_r[15];
                            shift_r <= {shift_r[14:0], 1'b0};
                        end else begin
                            shift_r <= {shift_r[14:0], mdioS};
                        end
                        if (bitCnt_r == PMCTL_DATA_BITS - 5'h01) begin
                            state_r <= ST_PRE;
                            ones_r <= '0;
                            mdioOe <= 1'b0;
                            mdioOut <= 1'b0;
                            if (wrHit) begin
                                wrStb_r <= 1'b1;
                                wrData_r <= {shift_r[14:0], mdioS};
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_PRE;
                        ones_r <= '0;
                        mdioOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register and soft reset
    // ----------------------------------------------------------------
    // reset and write
    // soft reset sequence
    // A new bit-15 write during soft reset restarts the count: set beats clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlReg_r <= PMCTL_CTRL_RESET;
            rstCnt_r <= '0;
        end else if (wrStb_r && wrData_r[PMCTL_BIT_SOFT_RESET]) begin
            ctrlReg_r <= PMCTL_CTRL_RESET | 16'h8000;
            rstCnt_r <= '0;
        end else if (ctrlReg_r[PMCTL_BIT_SOFT_RESET]) begin
            // Other writes are dropped while the reset runs
            rstCnt_r <= rstCnt_r + 16'h0001;
            if (rstCnt_r == RST_LAST) begin
                ctrlReg_r[PMCTL_BIT_SOFT_RESET] <= 1'b0;
                rstCnt_r <= '0;
            end
        end else if (wrStb_r) begin
            ctrlReg_r <= wrData_r & PMCTL_CTRL_WRITE_MASK;
        end
    end

    assign phyStateRst = ctrlReg_r[PMCTL_BIT_SOFT_RESET];
    assign phyMode.lineRateSelect = ctrlReg_r[PMCTL_BIT_RATE_SEL];
    assign phyMode.anegEnable = ctrlReg_r[PMCTL_BIT_ANEG_EN];
    assign phyMode.anegRestart = ctrlReg_r[PMCTL_BIT_ANEG_RESTART];
    assign phyMode.powerDown = ctrlReg_r[PMCTL_BIT_POWER_DOWN];
    assign phyMode.isolate = ctrlReg_r[PMCTL_BIT_ISOLATE];
    assign phyMode.duplexFull = ctrlReg_r[PMCTL_BIT_DUPLEX];
    assign phyMode.collisionTest = ctrlReg_r[PMCTL_BIT_COL_TEST];

    // ----------------------------------------------------------------
    // Data path steering
    // ----------------------------------------------------------------
    // loopback steering
    // Loopback takes priority over isolate so a self test works while isolated
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lineTxd <= '0;
            lineTxEn <= 1'b0;
            macRxd <= '0;
            macRxDv <= 1'b0;
        end else if (phyStateRst || ctrlReg_r[PMCTL_BIT_POWER_DOWN]) begin
            lineTxd <= '0;
            lineTxEn <= 1'b0;
            macRxd <= '0;
            macRxDv <= 1'b0;
        end else if (ctrlReg_r[PMCTL_BIT_LOOPBACK]) begin
            lineTxd <= '0;
            lineTxEn <= 1'b0;
            macRxd <= macTxd;
            macRxDv <= macTxEn;
        end else if (ctrlReg_r[PMCTL_BIT_ISOLATE]) begin
            lineTxd <= '0;
            lineTxEn <= 1'b0;
            macRxd <= '0;
            macRxDv <= 1'b0;
        end else begin
            lineTxd <= macTxd;
            lineTxEn <= macTxEn;
            macRxd <= lineRxd;
            macRxDv <= lineRxDv;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_reset_value: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(sys_rst) |-> ctrlReg_r == PMCTL_CTRL_RESET)
        else $error("control register not at reset value");

    a_write_lands: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wrStb_r && !wrData_r[15] && !ctrlReg_r[15]
        |=> ctrlReg_r == ($past(wrData_r) & PMCTL_CTRL_WRITE_MASK))
        else $error("management write not stored");

    a_normal_default: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(sys_rst) |-> !phyMode.powerDown && !phyMode.isolate
            && !ctrlReg_r[PMCTL_BIT_LOOPBACK] && phyMode.anegEnable)
        else $error("reset defaults not in normal operation");

    a_soft_defaults: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wrStb_r && wrData_r[15] |=> (phyStateRst
            && ctrlReg_r == (PMCTL_CTRL_RESET | 16'h8000)) ##1 (!macRxDv && !lineTxEn))
        else $error("soft reset did not restore defaults");

    a_soft_selfclear: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        phyStateRst && rstCnt_r == RST_LAST && !wrStb_r |=> !phyStateRst && rdValue[15] == 1'b0)
        else $error("soft reset bit did not clear");

    a_soft_bounded: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        phyStateRst |-> rstCnt_r <= RST_LAST)
        else $error("soft reset ran past its time");

    a_loop_detach: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ctrlReg_r[PMCTL_BIT_LOOPBACK] && $stable(ctrlReg_r) |=> !lineTxEn && lineTxd == 4'h0)
        else $error("medium driven during loopback");

    a_loop_return: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ctrlReg_r[PMCTL_BIT_LOOPBACK] && !ctrlReg_r[15] && !ctrlReg_r[11]
        |=> macRxDv == $past(macTxEn) && macRxd == $past(macTxd))
        else $error("loopback data not returned to MAC");

    a_rate_select: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wrStb_r && !wrData_r[15] && !ctrlReg_r[15]
        |=> phyMode.lineRateSelect == $past(wrData_r[13]))
        else $error("rate select not following register");
endmodule

// [pmctl_pkg.sv]
// Purpose: Shared constants and types for the PHY basic control register block.
// Assumes: One 100 MHz reference clock; the management frame arrives on sampled pins.
// Notes:   The field positions and reset value are those of management register 0.
package pmctl_pkg;

    // ----------------------------------------------------------------
    // Register map and field layout
    // ----------------------------------------------------------------
    localparam logic [4:0] PMCTL_REG_BASIC_CONTROL = 5'h00;
    localparam logic [15:0] PMCTL_CTRL_RESET = 16'h3100;
    // Bits 6:0 are reserved: stored as zero, read as zero
    localparam logic [15:0] PMCTL_CTRL_WRITE_MASK = 16'hff80;
    localparam int PMCTL_BIT_SOFT_RESET = 15;
    localparam int PMCTL_BIT_LOOPBACK = 14;
    localparam int PMCTL_BIT_RATE_SEL = 13;
    localparam int PMCTL_BIT_ANEG_EN = 12;
    localparam int PMCTL_BIT_POWER_DOWN = 11;
    localparam int PMCTL_BIT_ISOLATE = 10;
    localparam int PMCTL_BIT_ANEG_RESTART = 9;
    localparam int PMCTL_BIT_DUPLEX = 8;
    localparam int PMCTL_BIT_COL_TEST = 7;

    // ----------------------------------------------------------------
    // Management frame layout
    // ----------------------------------------------------------------
    localparam logic [5:0] PMCTL_PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] PMCTL_HDR_BITS = 5'h0c;
    localparam logic [4:0] PMCTL_DATA_BITS = 5'h10;
    localparam logic [1:0] PMCTL_OP_READ = 2'h2;
    localparam logic [1:0] PMCTL_OP_WRITE = 2'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int PMCTL_CLK_PERIOD_NS = 10;
    localparam int PMCTL_SOFT_RST_TIME_NS = 1000;
    // Least time, so round up
    localparam int PMCTL_SOFT_RST_CYCLES =
        (PMCTL_SOFT_RST_TIME_NS + PMCTL_CLK_PERIOD_NS - 1) / PMCTL_CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_PRE = 3'b000,
        ST_START = 3'b001,
        ST_HDR = 3'b010,
        ST_TA = 3'b011,
        ST_DATA = 3'b100
    } pmctl_state_t;

    // Operating mode fields handed to the rest of the PHY
    typedef struct packed {
        logic lineRateSelect;
        logic anegEnable;
        logic anegRestart;
        logic powerDown;
        logic isolate;
        logic duplexFull;
        logic collisionTest;
    } pmctl_mode_t;

endpackage

// [pmctl_sync2.sv]
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are slow against the reference clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module pmctl_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk, // Reference clock
    input wire logic sys_rst, // Async reset, high
    input wire logic [WIDTH-1:0] din, // Asynchronous input
    output logic [WIDTH-1:0] dout // Synchronised output
);
    logic [WIDTH-1:0] meta_r;

    // Width must be meaningful
    if (WIDTH < 1) begin : g_bad_width
        $error("pmctl_sync2: WIDTH must be at least 1");
    end

    // Two flops in a row, nothing taps the first
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// [pmctl_tb.sv]
// Purpose: Self-checking bench for the PHY basic control register block.
// Assumes: Short soft reset count and a nonzero PHY address to keep runs brief.
// Notes:   Expected values come from a register model kept in the bench.
`timescale 1ns/1ps
module testbench;
    import pmctl_pkg::*;
    localparam int RST_CYC = 8;
    localparam logic [4:0] MY_ADDR = 5'h05;
    logic ref_clk, sys_rst, mdc, mdioOut, mdioOe, mdioDrv, mdioDrvEn, mdioWire;
    logic [3:0] macTxd, macRxd, lineTxd, lineRxd;
    logic macTxEn, macRxDv, lineTxEn, lineRxDv, phyStateRst;
    pmctl_mode_t phyMode;
    logic [15:0] regModel;
    logic [15:0] vals[$];
    int n_errors, n_compared, rstRun, rstLen, seedVal;

    // ----------------------------------------------------------------
    // Clock, wire and instances
    // ----------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    // Released wire floats to its pull-up
    assign mdioWire = mdioOe ? mdioOut : (mdioDrvEn ? mdioDrv : 1'b1);

    pmctl_phy_ctrl #(.PHY_ADDR(MY_ADDR), .SOFT_RST_CYCLES(RST_CYC)) pmctl_phy_ctrl_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioWire),
        .mdioOut(mdioOut), .mdioOe(mdioOe), .macTxd(macTxd), .macTxEn(macTxEn),
        .macRxd(macRxd), .macRxDv(macRxDv), .lineTxd(lineTxd), .lineTxEn(lineTxEn),
        .lineRxd(lineRxd), .lineRxDv(lineRxDv), .phyStateRst(phyStateRst), .phyMode(phyMode));
    pmctl_mgmt_model pmctl_mgmt_model_i (.ref_clk(ref_clk), .mdc(mdc), .mdioDrv(mdioDrv),
        .mdioDrvEn(mdioDrvEn), .mdioWire(mdioWire));

    // Length of the last soft reset pulse, in cycles
    always @(posedge ref_clk) begin
        if (phyStateRst === 1'b1) begin
            rstRun <= rstRun + 1;
        end else if (rstRun != 0) begin
            rstLen <= rstRun;
            rstRun <= 0;
        end
    end

    // ----------------------------------------------------------------
    // Model and compare helpers
    // ----------------------------------------------------------------
    function automatic pmctl_mode_t modeOf(input logic [15:0] v);
        return pmctl_mode_t'({v[13], v[12], v[9], v[11], v[10], v[8], v[7]});
    endfunction

    // Power down silences all; loopback beats isolate
    function automatic logic [9:0] pathOf(input logic [15:0] v, input logic [4:0] tx,
            input logic [4:0] rx);
        if (v[11] || (v[10] && !v[14])) begin
            return 10'h000;
        end
        return v[14] ? {tx, 5'h00} : {rx, tx};
    endfunction

    task automatic chkWord(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkMode(input pmctl_mode_t exp);
        n_compared++;
        if (phyMode !== exp) begin
            n_errors++;
            $display("ERROR mode expected %b seen %b", exp, phyMode);
        end
    endtask

    task automatic chkPath(input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR data path expected %h seen %h", exp, got);
        end
    endtask

    // Random nibbles through the data path, one cycle latency
    task automatic checkPath();
        logic [4:0] tx, rx;
        repeat (6) begin
            @(posedge ref_clk);
            tx = 5'($urandom);
            rx = 5'($urandom);
            {macTxd, macTxEn} <= tx;
            {lineRxd, lineRxDv} <= rx;
            @(posedge ref_clk);
            #1;
            chkPath(pathOf(regModel, tx, rx), {macRxd, macRxDv, lineTxd, lineTxEn});
        end
    endtask

    task automatic regWrite(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] rd;
        logic ta;
        pmctl_mgmt_model_i.runFrame(PMCTL_OP_WRITE, pa, ra, d, rd, ta);
        if (pa == MY_ADDR && ra == 5'h00) begin
            regModel = d[15] ? 16'h3100 : (d & 16'hff80);
        end
    endtask

    // Turnaround second bit is driven low only by an answering PHY
    task automatic checkRead(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp,
            input logic expTa);
        logic [15:0] rd;
        logic ta;
        pmctl_mgmt_model_i.runFrame(PMCTL_OP_READ, pa, ra, 16'h0000, rd, ta);
        chkWord("read data", exp, rd);
        chkWord("turnaround", {15'h0000, expTa}, {15'h0000, ta});
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seedVal = $urandom(24042);
        sys_rst = 1'b1;
        {macTxd, macTxEn, lineRxd, lineRxDv} = 10'h000;
        n_errors = 0;
        n_compared = 0;
        rstRun = 0;
        rstLen = 0;
        regModel = 16'h3100;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chkMode(modeOf(16'h3100));
        checkPath();
        checkRead(MY_ADDR, 5'h00, 16'h3100, 1'b0);
        // Modes, boundary values, reserved bits, then random words
        vals = '{16'h4000, 16'h0000, 16'h6400, 16'h0800, 16'h0400, 16'h207f};
        repeat (3) vals.push_back(16'($urandom) & 16'h7fff);
        foreach (vals[i]) begin
            regWrite(MY_ADDR, 5'h00, vals[i]);
            chkMode(modeOf(regModel));
            checkPath();
            checkRead(MY_ADDR, 5'h00, regModel, 1'b0);
        end
        // Other register and other PHY address leave the word alone
        regWrite(MY_ADDR, 5'h01, 16'h0000);
        regWrite(MY_ADDR ^ 5'h01, 5'h00, 16'h0000);
        checkRead(MY_ADDR, 5'h00, regModel, 1'b0);
        checkRead(MY_ADDR, 5'h01, 16'hffff, 1'b1);
        // Soft reset out of loopback, pulse length and self-clear
        regWrite(MY_ADDR, 5'h00, 16'h4000);
        rstLen = 0;
        // MAC keeps transmitting so the loopback return is live when reset hits
        macTxEn <= 1'b1;
        regWrite(MY_ADDR, 5'h00, 16'hc000);
        for (int k = 0; k < 50 && rstLen == 0; k++) begin
            @(posedge ref_clk);
        end
        chkWord("soft reset length", 16'(RST_CYC), 16'(rstLen));
        chkMode(modeOf(16'h3100));
        checkPath();
        checkRead(MY_ADDR, 5'h00, 16'h3100, 1'b0);
        // Second system reset in mid-run
        regWrite(MY_ADDR, 5'h00, 16'h0000);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        regModel = 16'h3100;
        repeat (3) @(posedge ref_clk);
        chkMode(modeOf(16'h3100));
        checkRead(MY_ADDR, 5'h00, 16'h3100, 1'b0);
        report_and_stop();
    end
endmodule
